// >>> inc/scirq_regs.vh
/*
  Register offsets, field positions and reset values for the serial
  interrupt and receive-error status block.
  Assumes a byte-wide plain register port with read data one cycle late.
*/
`ifndef SCIRQ_REGS_VH
`define SCIRQ_REGS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SCIRQ_ADDR_W 3
`define SCIRQ_OFS_CTRL 3'h0
`define SCIRQ_OFS_STAT 3'h1
`define SCIRQ_OFS_TXD 3'h2
`define SCIRQ_OFS_RXD 3'h3
`define SCIRQ_OFS_ISTAT 3'h4
`define SCIRQ_OFS_IMASK 3'h5

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define SCIRQ_CTRL_TXE_IE 7
`define SCIRQ_CTRL_RX_IE 6
`define SCIRQ_CTRL_TX_COMPLETE_FLAG_IE 2
`define SCIRQ_CTRL_RST 8'h00

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define SCIRQ_ST_TXE 7
`define SCIRQ_ST_RXF 6
`define SCIRQ_ST_OVR 5
`define SCIRQ_ST_FRM 4
`define SCIRQ_ST_PAR 3
`define SCIRQ_ST_TX_COMPLETE_FLAG 2
`define SCIRQ_STAT_RST 8'h84
`define SCIRQ_TXD_RST 8'hFF
`define SCIRQ_RXD_RST 8'h00

// ---------------------------------------------------------------
// event status / mask fields (one bit per request line)
// ---------------------------------------------------------------
`define SCIRQ_EV_ERR 0
`define SCIRQ_EV_RXF 1
`define SCIRQ_EV_TXE 2
`define SCIRQ_EV_TX_COMPLETE_FLAG 3
`define SCIRQ_EV_W 4
`define SCIRQ_EV_RST 4'h0

// priority vector codes
`define SCIRQ_VEC_NONE 3'h0
`define SCIRQ_VEC_ERR 3'h1
`define SCIRQ_VEC_RXF 3'h2
`define SCIRQ_VEC_TXE 3'h3
`define SCIRQ_VEC_TX_COMPLETE_FLAG 3'h4

`endif

// >>> core/scirq_prio.v
/*
  Fixed-priority encoder for the four serial request lines.
  Assumes request bits are ordered error, rx full, tx empty, tx end.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scirq_regs.vh"

module scirq_prio (
  input wire [`SCIRQ_EV_W-1:0] req_i,
  output reg [2:0] vec_o
);

  always @* begin
    if (req_i[`SCIRQ_EV_ERR]) begin // see (R7)
      vec_o = `SCIRQ_VEC_ERR;
    end else if (req_i[`SCIRQ_EV_RXF]) begin
      vec_o = `SCIRQ_VEC_RXF;
    end else if (req_i[`SCIRQ_EV_TXE]) begin
      vec_o = `SCIRQ_VEC_TXE;
    end else if (req_i[`SCIRQ_EV_TX_COMPLETE_FLAG]) begin
      vec_o = `SCIRQ_VEC_TX_COMPLETE_FLAG;
    end else begin
      vec_o = `SCIRQ_VEC_NONE;
    end
  end

endmodule
`default_nettype wire

// >>> core/scirq_core.v
/*
  Interrupt request and receive-error status part of a serial unit:
  control enables, status flags, tx data / rx data hand-over, four
  request lines, priority vector and a summary interrupt.
  Assumes the serial engines (shifter, framing) sit outside on the
  same clock and talk through the one-cycle pulse ports below.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scirq_regs.vh"

// What this block does
// (R1) four separate request lines to interrupt controller
// (R2) three control enables gate the four requests
// (R3) tx empty request when empty flag sets
// (R4) tx end request when complete flag sets
// (R5) rx full request when full flag sets
// (R6) error request on overrun, parity or framing
// (R7) fixed priority: error, rx, tx empty, end
// (R8) empty flag sets on data-to-shifter move
// (R9) tx data writes always accepted, may overwrite
// (R10) software checks empty flag before writing
// (R11) overrun blocks shift-to-data register copy
// (R12) three error flags set independently
// (R13) framing/parity only still copies character
// (R14) requests are levels: flag and enable
module scirq_core #(
  parameter DATA_W = 8
) (
  input wire clk_i,
  input wire srst_i,
  // register port
  input wire [`SCIRQ_ADDR_W-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // transmit engine side
  input wire tx_load_i,
  output wire [DATA_W-1:0] tx_shift_data_o,
  output wire tx_data_pending_o,
  input wire tx_done_i,
  // receive engine side
  input wire rx_done_i,
  input wire [DATA_W-1:0] rx_shift_reg_i,
  input wire rx_frm_err_i,
  input wire rx_par_err_i,
  // request lines
  output wire tx_end_irq_o,
  output wire rx_error_irq_o,
  output wire rx_full_irq_o,
  output wire tx_empty_irq_o,
  output wire [2:0] irq_vec_o,
  output wire irq_o
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  reg [7:0] serial_control_reg_r;
  reg [DATA_W-1:0] tx_data_reg_r;
  reg [DATA_W-1:0] rx_data_reg_r;
  reg tx_buf_empty_flag_r;
  reg tx_complete_flag_r;
  reg rx_buf_full_flag_r;
  reg overrun_flag_r;
  reg framing_err_flag_r;
  reg parity_err_flag_r;
  reg [`SCIRQ_EV_W-1:0] ev_stat_r;
  reg [`SCIRQ_EV_W-1:0] ev_mask_r;
  reg [`SCIRQ_EV_W-1:0] req_d_r;

  wire [7:0] status_view;
  wire [`SCIRQ_EV_W-1:0] req;
  wire [`SCIRQ_EV_W-1:0] req_rise;
  wire wr_ctrl;
  wire wr_stat;
  wire wr_txd;
  wire wr_istat;
  wire wr_imask;
  wire rx_overrun;
  wire rx_copy;

  // reset image of the status register, so single flag bits can be picked
  localparam [7:0] STAT_RST = `SCIRQ_STAT_RST;

  function sel;
    input [`SCIRQ_ADDR_W-1:0] a;
    input [`SCIRQ_ADDR_W-1:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  assign wr_ctrl = reg_wr_i & sel(reg_addr_i, `SCIRQ_OFS_CTRL);
  assign wr_stat = reg_wr_i & sel(reg_addr_i, `SCIRQ_OFS_STAT);
  assign wr_txd = reg_wr_i & sel(reg_addr_i, `SCIRQ_OFS_TXD);
  assign wr_istat = reg_wr_i & sel(reg_addr_i, `SCIRQ_OFS_ISTAT);
  assign wr_imask = reg_wr_i & sel(reg_addr_i, `SCIRQ_OFS_IMASK);

  assign status_view = {tx_buf_empty_flag_r, rx_buf_full_flag_r, overrun_flag_r,
                        framing_err_flag_r, parity_err_flag_r, tx_complete_flag_r, 2'h0};

  // ---------------------------------------------------------------
  // receive hand-over
  // ---------------------------------------------------------------
  // a character arriving while the data register is still full is an overrun
  assign rx_overrun = rx_done_i & rx_buf_full_flag_r;
  assign rx_copy = rx_done_i & ~rx_overrun; // see (R11) see (R13)

  always @(posedge clk_i) begin
    if (srst_i) begin
      rx_data_reg_r <= `SCIRQ_RXD_RST;
    end else if (rx_copy) begin
      rx_data_reg_r <= rx_shift_reg_i; // see (R13)
    end
  end

  // ---------------------------------------------------------------
  // status flags: hardware set wins over software clear, except a tx data write beats the complete-flag set
  // ---------------------------------------------------------------
  // status bits clear by writing 0 to a bit that reads 1
  always @(posedge clk_i) begin
    if (srst_i) begin
      tx_buf_empty_flag_r <= STAT_RST[`SCIRQ_ST_TXE];
      tx_complete_flag_r <= STAT_RST[`SCIRQ_ST_TX_COMPLETE_FLAG];
      rx_buf_full_flag_r <= 1'b0;
      overrun_flag_r <= 1'b0;
      framing_err_flag_r <= 1'b0;
      parity_err_flag_r <= 1'b0;
    end else begin
      if (tx_load_i) begin
        tx_buf_empty_flag_r <= 1'b1; // see (R8)
      end else if (wr_txd) begin
        tx_buf_empty_flag_r <= 1'b0; // see (R9)
      end else if (wr_stat & ~reg_wdata_i[`SCIRQ_ST_TXE]) begin
        tx_buf_empty_flag_r <= 1'b0;
      end
      if (tx_done_i & tx_buf_empty_flag_r & ~wr_txd) begin
        tx_complete_flag_r <= 1'b1;
      end else if (wr_txd | (wr_stat & ~reg_wdata_i[`SCIRQ_ST_TX_COMPLETE_FLAG])) begin
        tx_complete_flag_r <= 1'b0;
      end
      if (rx_copy) begin
        rx_buf_full_flag_r <= 1'b1;
      end else if (wr_stat & ~reg_wdata_i[`SCIRQ_ST_RXF]) begin
        rx_buf_full_flag_r <= 1'b0;
      end
      // each error flag has its own set term  see (R12)
      if (rx_overrun) begin
        overrun_flag_r <= 1'b1;
      end else if (wr_stat & ~reg_wdata_i[`SCIRQ_ST_OVR]) begin
        overrun_flag_r <= 1'b0;
      end
      if (rx_done_i & rx_frm_err_i) begin
        framing_err_flag_r <= 1'b1;
      end else if (wr_stat & ~reg_wdata_i[`SCIRQ_ST_FRM]) begin
        framing_err_flag_r <= 1'b0;
      end
      if (rx_done_i & rx_par_err_i) begin
        parity_err_flag_r <= 1'b1;
      end else if (wr_stat & ~reg_wdata_i[`SCIRQ_ST_PAR]) begin
        parity_err_flag_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control and transmit data
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      serial_control_reg_r <= `SCIRQ_CTRL_RST;
      tx_data_reg_r <= `SCIRQ_TXD_RST;
      ev_mask_r <= `SCIRQ_EV_RST;
    end else begin
      if (wr_ctrl) begin
        serial_control_reg_r <= reg_wdata_i;
      end
      // no guard: a pending character is simply replaced  see (R9) (R10)
      if (wr_txd) begin
        tx_data_reg_r <= reg_wdata_i[DATA_W-1:0];
      end
      if (wr_imask) begin
        ev_mask_r <= reg_wdata_i[`SCIRQ_EV_W-1:0];
      end
    end
  end

  assign tx_shift_data_o = tx_data_reg_r;
  assign tx_data_pending_o = ~tx_buf_empty_flag_r;

  // ---------------------------------------------------------------
  // request lines
  // ---------------------------------------------------------------
  // plain levels so the controller sees them until the flag clears
  assign req[`SCIRQ_EV_ERR] = serial_control_reg_r[`SCIRQ_CTRL_RX_IE] &
                              (overrun_flag_r | framing_err_flag_r | parity_err_flag_r); // see (R6) (R14)
  assign req[`SCIRQ_EV_RXF] = serial_control_reg_r[`SCIRQ_CTRL_RX_IE] & rx_buf_full_flag_r; // see (R5) (R2)
  assign req[`SCIRQ_EV_TXE] = serial_control_reg_r[`SCIRQ_CTRL_TXE_IE] & tx_buf_empty_flag_r; // see (R3) (R2)
  assign req[`SCIRQ_EV_TX_COMPLETE_FLAG] = serial_control_reg_r[`SCIRQ_CTRL_TX_COMPLETE_FLAG_IE] & tx_complete_flag_r; // see (R4) (R2)

  assign rx_error_irq_o = req[`SCIRQ_EV_ERR]; // see (R1)
  assign rx_full_irq_o = req[`SCIRQ_EV_RXF];
  assign tx_empty_irq_o = req[`SCIRQ_EV_TXE];
  assign tx_end_irq_o = req[`SCIRQ_EV_TX_COMPLETE_FLAG];

  scirq_prio u_prio (
    .req_i(req),
    .vec_o(irq_vec_o)
  );

  // ---------------------------------------------------------------
  // sticky event status and summary interrupt
  // ---------------------------------------------------------------
  assign req_rise = req & ~req_d_r;

  always @(posedge clk_i) begin
    if (srst_i) begin
      req_d_r <= `SCIRQ_EV_RST;
      ev_stat_r <= `SCIRQ_EV_RST;
    end else begin
      req_d_r <= req;
      // new rising edge beats a write-one-to-clear in the same cycle
      ev_stat_r <= (ev_stat_r & ~({`SCIRQ_EV_W{wr_istat}} & reg_wdata_i[`SCIRQ_EV_W-1:0])) | req_rise;
    end
  end

  assign irq_o = |(ev_stat_r & ev_mask_r);

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SCIRQ_OFS_CTRL: reg_rdata_o <= serial_control_reg_r;
        `SCIRQ_OFS_STAT: reg_rdata_o <= status_view;
        `SCIRQ_OFS_TXD: reg_rdata_o <= tx_data_reg_r;
        `SCIRQ_OFS_RXD: reg_rdata_o <= rx_data_reg_r;
        `SCIRQ_OFS_ISTAT: reg_rdata_o <= {4'h0, ev_stat_r};
        `SCIRQ_OFS_IMASK: reg_rdata_o <= {4'h0, ev_mask_r};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// >>> tb/scirq_core_sva.sv
/* port checker for the serial request block.
   assumes one clock, bound onto scirq_core by the bench. */
`timescale 1ns/10ps
`default_nettype none
`include "scirq_regs.vh"
module scirq_core_sva #(
  parameter DATA_W = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic tx_load_i,
  input wire logic rx_done_i,
  input wire logic [DATA_W-1:0] tx_shift_data_o,
  input wire logic tx_data_pending_o,
  input wire logic tx_end_irq_o,
  input wire logic rx_error_irq_o,
  input wire logic rx_full_irq_o,
  input wire logic tx_empty_irq_o,
  input wire logic [2:0] irq_vec_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire txd_wr = reg_wr_i && reg_addr_i == `SCIRQ_OFS_TXD;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  vec_prio_a: assert property (
    irq_vec_o == (rx_error_irq_o ? `SCIRQ_VEC_ERR : rx_full_irq_o ? `SCIRQ_VEC_RXF :
    tx_empty_irq_o ? `SCIRQ_VEC_TXE : tx_end_irq_o ? `SCIRQ_VEC_TX_COMPLETE_FLAG : `SCIRQ_VEC_NONE))
    else $error("priority vector wrong");
  txe_level_a: assert property (tx_empty_irq_o |-> !tx_data_pending_o)
    else $error("tx empty request while data pending");
  tx_complete_flag_level_a: assert property ($rose(tx_end_irq_o) |-> !tx_data_pending_o || $past(reg_wr_i))
    else $error("tx end request while data pending");
  load_empty_a: assert property (tx_load_i && !txd_wr |=> !tx_data_pending_o)
    else $error("empty flag not set on load");
  txd_write_a: assert property (txd_wr && !tx_load_i |=> tx_data_pending_o &&
    !tx_empty_irq_o && !tx_end_irq_o && tx_shift_data_o == $past(reg_wdata_i))
    else $error("tx data write not taken");
  rxf_rise_a: assert property ($rose(rx_full_irq_o) |-> $past(rx_done_i) || $past(reg_wr_i))
    else $error("rx full request without cause");
  err_rise_a: assert property ($rose(rx_error_irq_o) |-> $past(rx_done_i) || $past(reg_wr_i))
    else $error("error request without cause");
  rxf_hold_a: assert property (rx_full_irq_o && !reg_wr_i |=> rx_full_irq_o)
    else $error("rx full request dropped");
  err_hold_a: assert property (rx_error_irq_o && !reg_wr_i |=> rx_error_irq_o)
    else $error("error request dropped");
  cover property (rx_error_irq_o && rx_full_irq_o);
  cover property ($rose(tx_end_irq_o));
  cover property ($rose(irq_o));
endmodule
`default_nettype wire

// >>> tb/scirq_eng_model.sv
/* behavioural transmit engine on the far side of the block.
   assumes the block's tx hand-over pulses on one shared clock. */
`timescale 1ns/10ps
`default_nettype none
module scirq_eng_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic hold_i,
  input wire logic pending_i,
  input wire logic [7:0] data_i,
  output logic load_o,
  output logic done_o,
  output logic [7:0] sent_o
);
  logic [3:0] cnt_r;
  // hold_i stops an idle engine from loading, so writes can pile up in the data register
  always @(posedge clk_i) begin
    load_o <= 1'h0;
    done_o <= 1'h0;
    if (srst_i) begin
      cnt_r <= 4'h0;
      sent_o <= 8'h00;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      done_o <= cnt_r == 4'h1;
    end else if (pending_i && !hold_i) begin
      load_o <= 1'h1;
      sent_o <= data_i;
      cnt_r <= 4'h8;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_scirq_core.sv
/* self-checking bench for scirq_core with a stallable tx engine.
   assumes the include path reaches scirq_regs.vh. */
`timescale 1ns/10ps
`default_nettype none
`include "scirq_regs.vh"
module tb_scirq_core;
  logic clk_i = 0, srst_i = 1, wr_s = 0, rd_s = 0, hold = 1, rx_done = 0, frm = 0, par = 0;
  logic [2:0] addr = 0;
  logic [7:0] wdata = 0, rx_data = 0, d, a, b;
  logic [31:0] seed = 32'h6B1EA0EF;
  wire [7:0] rdata, txd, sent;
  wire [2:0] vec;
  wire pend, load, done, tx_end_irq, rx_error_irq, rx_full_irq, tx_empty_irq, irq;
  int errors = 0, tests_run = 0, cyc = 0, i;
  logic [7:0] rst_tab [8] = '{8'h00, 8'h84, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #12.5 clk_i = ~clk_i;
  scirq_core #(.DATA_W(8)) scirq_core_i (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .tx_load_i(load),
    .tx_shift_data_o(txd), .tx_data_pending_o(pend), .tx_done_i(done), .rx_done_i(rx_done),
    .rx_shift_reg_i(rx_data), .rx_frm_err_i(frm), .rx_par_err_i(par), .tx_end_irq_o(tx_end_irq),
    .rx_error_irq_o(rx_error_irq), .rx_full_irq_o(rx_full_irq), .tx_empty_irq_o(tx_empty_irq), .irq_vec_o(vec), .irq_o(irq));
  scirq_eng_model scirq_eng_model_i (.clk_i(clk_i), .srst_i(srst_i), .hold_i(hold), .pending_i(pend),
    .data_i(txd), .load_o(load), .done_o(done), .sent_o(sent));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function logic [2:0] exp_vec(input logic e, input logic r, input logic t, input logic n);
    return e ? `SCIRQ_VEC_ERR : r ? `SCIRQ_VEC_RXF : t ? `SCIRQ_VEC_TXE : n ? `SCIRQ_VEC_TX_COMPLETE_FLAG : `SCIRQ_VEC_NONE;
  endfunction
  function logic [7:0] exp_st(input logic o, input logic f, input logic p);
    return {2'h1, o, f, p, 3'h0};
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tick;
    @(posedge clk_i);
    #1;
  endtask
  task wr(input logic [2:0] ad, input logic [7:0] dd);
    @(posedge clk_i);
    addr <= ad;
    wdata <= dd;
    wr_s <= 1;
    @(posedge clk_i);
    wr_s <= 0;
  endtask
  task rd(input logic [2:0] ad, output logic [7:0] dd);
    @(posedge clk_i);
    addr <= ad;
    rd_s <= 1;
    @(posedge clk_i);
    rd_s <= 0;
    #1 dd = rdata;
  endtask
  task rxc(input logic [7:0] dd, input logic f, input logic p);
    @(posedge clk_i);
    rx_data <= dd;
    frm <= f;
    par <= p;
    rx_done <= 1;
    @(posedge clk_i);
    rx_done <= 0;
    rx_data <= ~dd;
  endtask
  task give_verdict;
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      give_verdict;
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 0;
    for (i = 0; i < 8; i++) begin
      rd(i[2:0], d);
      chk(d, rst_tab[i]);
    end
    wr(`SCIRQ_OFS_CTRL, 8'hC4);
    tick;
    chk({tx_empty_irq, tx_end_irq, vec}, {2'h3, exp_vec(0, 0, 1, 1)});
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      a = seed[7:0];
      b = seed[15:8];
      rd(`SCIRQ_OFS_STAT, d);
      chk(d[7], 1);
      wr(`SCIRQ_OFS_TXD, a);
      wr(`SCIRQ_OFS_TXD, b);
      tick;
      chk({txd, pend, tx_empty_irq, tx_end_irq}, {b, 3'h4});
      @(posedge clk_i);
      hold <= 0;
      repeat (3) tick;
      chk({sent, pend, tx_empty_irq}, {b, 2'h1});
      repeat (12) tick;
      chk({tx_end_irq, vec}, {1'h1, exp_vec(0, 0, 1, 1)});
      @(posedge clk_i);
      hold <= 1;
    end
    for (i = 0; i < 8; i++) begin
      wr(`SCIRQ_OFS_STAT, 8'h84);
      seed = xs(seed);
      a = seed[7:0];
      b = seed[23:16];
      if (i[2]) rxc(a, 0, 0);
      rxc(b, i[1], i[0]);
      tick;
      rd(`SCIRQ_OFS_STAT, d);
      chk(d & 8'h78, exp_st(i[2], i[1], i[0]));
      rd(`SCIRQ_OFS_RXD, d);
      chk(d, i[2] ? a : b);
      chk({rx_error_irq, rx_full_irq, vec}, {i != 0, 1'h1, exp_vec(i != 0, 1, 1, 1)});
    end
    wr(`SCIRQ_OFS_IMASK, 8'h0F);
    tick;
    chk(irq, 1);
    wr(`SCIRQ_OFS_IMASK, 8'h00);
    tick;
    chk(irq, 0);
    wr(`SCIRQ_OFS_ISTAT, 8'h0F);
    wr(`SCIRQ_OFS_IMASK, 8'h0F);
    tick;
    chk(irq, 0);
    wr(`SCIRQ_OFS_STAT, 8'h84);
    rxc(8'h5A, 1, 0);
    rd(`SCIRQ_OFS_ISTAT, d);
    chk({d, irq}, {8'h03, 1'h1});
    wr(`SCIRQ_OFS_CTRL, 8'h40);
    tick;
    chk({rx_error_irq, rx_full_irq, tx_empty_irq, tx_end_irq}, 4'hC);
    wr(`SCIRQ_OFS_CTRL, 8'h00);
    tick;
    chk({rx_error_irq, rx_full_irq, tx_empty_irq, tx_end_irq, vec}, 7'h00);
    give_verdict;
  end
endmodule
bind scirq_core scirq_core_sva #(.DATA_W(DATA_W)) scirq_core_sva_i (.clk_i(clk_i), .srst_i(srst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .tx_load_i(tx_load_i),
  .rx_done_i(rx_done_i), .tx_shift_data_o(tx_shift_data_o), .tx_data_pending_o(tx_data_pending_o),
  .tx_end_irq_o(tx_end_irq_o), .rx_error_irq_o(rx_error_irq_o), .rx_full_irq_o(rx_full_irq_o),
  .tx_empty_irq_o(tx_empty_irq_o), .irq_vec_o(irq_vec_o), .irq_o(irq_o));
`default_nettype wire
